// ==== hdl/wpt_defines.svh ====
// timing counts, field widths and reset values of the phase sequencer
`ifndef WPT_DEFINES_SVH
`define WPT_DEFINES_SVH

`define WPT_CLK_PERIOD_NS   20
`define WPT_PING_TIME_US    65
`define WPT_PING_CYC        ((`WPT_PING_TIME_US * 1000) / `WPT_CLK_PERIOD_NS)
`define WPT_CEP_TIMEOUT_MS  1800
`define WPT_CEP_CYC         ((`WPT_CEP_TIMEOUT_MS * 1000000) / `WPT_CLK_PERIOD_NS)
`define WPT_BRIDGE_LOW      8'h10
`define WPT_BRIDGE_PING     8'h50
`define WPT_BRIDGE_OFF      8'h00
`define WPT_CAP_LOW_MW      16'h1388
`define WPT_PW              16

`endif

// ==== hdl/wpt_pkg.sv ====
// types of the wireless power phase sequencer
package wpt_pkg;
   typedef enum logic [3:0] {
      WPT_SELECT, WPT_PING, WPT_IDCFG, WPT_NEGO, WPT_CALIB, WPT_POWER
   } wpt_phase_t;

   typedef enum logic [1:0] {
      WPT_PROF_BASIC, WPT_PROF_EXT, WPT_PROF_MAG
   } wpt_prof_t;

   // decoded receiver packet events, one-cycle pulses
   typedef struct packed {
      logic        ssp;        // signal strength packet
      logic        cfg;        // configuration done
      logic        ext;        // receiver is extended profile
      logic        mag;        // receiver is magnetic profile
      logic [15:0] max_pwr;    // maximum required output power
      logic        nego_req;   // negotiation requested
      logic        nreq;       // contract adjust request
      logic [15:0] nreq_pwr;   // requested power
      logic        nego_end;   // negotiation finished
      logic        cal_req;    // calibration requested
      logic        cal_pt;     // calibration load point reported
      logic        cep;        // control error packet
      logic        ept;        // end power transmit
      logic        auth_ok;    // authentication succeeded
   } wpt_rx_t;

   typedef struct packed {
      wpt_phase_t  phase;
      wpt_prof_t   prof;
      logic [7:0]  bridge;
      logic        ping_on;
      logic [31:0] cnt;
      logic [15:0] contract;
      logic [15:0] cap;
      logic        authed;
      logic        alarm;
      logic        ack;
      logic        grant;
      logic        deny;
      logic [1:0]  cal_n;
      logic [15:0] loss0;
      logic [15:0] loss1;
      logic        fo;
   } wpt_state_t;
endpackage

// ==== hdl/wpt_phase_ctrl.sv ====
// phase sequencer of an inductive wireless power transmitter
`timescale 1ns/10ps
`default_nettype none
`include "wpt_defines.svh"

// How it works
// - selection senses objects with low energy probes
// - analog ping energy kept below receiver wake
// - selection commands low bridge supply voltage
// - digital ping has fixed magnitude and length
// - ping ends on silence or strength packet
// - valid strength packet extends ping, go identify
// - classify basic, extended or magnetic, remember it
// - capture max power, form transfer contract
// - basic profile goes straight to power
// - extended enters negotiation only on request
// - each negotiation request granted or denied, unless the quality factor check fails in that cycle
// - extended: compare reported and own quality factor
// - low own quality factor: alarm, reselect
// - calibration request acknowledged, then calibrate
// - measure losses at two load points, store
// - stored loss data detects foreign objects
// - basic profile skips negotiation and calibration
// - operating profile follows receiver capability
// - after calibration cap low until authenticated
// - no control error packet in time: withdraw
// - end power packet stops transfer at once
module wpt_phase_ctrl import wpt_pkg::*; #(
   parameter int unsigned PING_CYC = `WPT_PING_CYC,
   parameter int unsigned CEP_CYC  = `WPT_CEP_CYC,
   parameter logic [15:0] LOSS_TOL = 16'h01F4
) (
   input  wire logic        i_clk_sys,    // 50 MHz system clock
   input  wire logic        i_arst_n,     // async reset, active low
   input  wire logic        i_obj_seen,   // low energy probe saw change
   input  wire logic [15:0] i_q_own,      // own coil quality factor
   input  wire logic [15:0] i_q_min,      // own quality factor floor
   input  wire logic [15:0] i_q_rx,       // receiver reported quality
   input  wire logic [15:0] i_tx_pwr,     // transmitted power, mW
   input  wire logic [15:0] i_rx_pwr,     // received power, mW
   input  wire wpt_rx_t     i_rx,         // decoded receiver packets
   output logic [3:0]       o_phase,      // current phase
   output logic [1:0]       o_profile,    // operating profile
   output logic [7:0]       o_bridge_supply_voltage, // bridge setting
   output logic             o_ping_on,    // digital ping power on
   output logic             o_power_on,   // power transfer on
   output logic [15:0]      o_pwr_limit,  // delivered power limit
   output logic             o_quality_factor_object_alarm, // sticky
   output logic             o_cal_ack,    // calibration acknowledge
   output logic             o_grant,      // negotiation grant pulse
   output logic             o_deny,       // negotiation deny pulse
   output logic             o_fo_alarm    // foreign object found
);

   wpt_state_t st_ff;
   wpt_state_t nxt_st;
   logic [15:0] loss_now;
   logic [15:0] loss_ref;

   // measured loss versus calibrated baseline
   assign loss_now = (i_tx_pwr > i_rx_pwr) ? 16'(i_tx_pwr - i_rx_pwr)
                                           : 16'h0000;
   assign loss_ref = 16'(st_ff.loss0 + LOSS_TOL);

   // ========================================================
   // next state
   always_comb begin
      nxt_st       = st_ff;
      nxt_st.ack   = 1'b0;
      nxt_st.grant = 1'b0;
      nxt_st.deny  = 1'b0;
      nxt_st.cnt   = st_ff.cnt + 32'h0000_0001;
      case (st_ff.phase)
         WPT_SELECT: begin
            // only low probes run here, power never sent
            nxt_st.bridge  = `WPT_BRIDGE_LOW;
            nxt_st.ping_on = 1'b0;
            nxt_st.fo      = 1'b0;
            if (i_obj_seen) begin
               // ping power starts with the phase, so its length is exact
               nxt_st.phase   = WPT_PING;
               nxt_st.bridge  = `WPT_BRIDGE_PING;
               nxt_st.ping_on = 1'b1;
               nxt_st.cnt     = 32'h0000_0000;
               nxt_st.alarm   = 1'b0;
               nxt_st.authed  = 1'b0;
               nxt_st.cal_n   = 2'h0;
            end
         end
         WPT_PING: begin
            nxt_st.bridge  = `WPT_BRIDGE_PING;
            nxt_st.ping_on = 1'b1;
            if (i_rx.ssp) begin
               // ping stays on past its normal length
               nxt_st.phase = WPT_IDCFG;
               nxt_st.cnt   = 32'h0000_0000;
            end else if (st_ff.cnt >= PING_CYC - 1) begin
               nxt_st.phase   = WPT_SELECT;
               nxt_st.bridge  = `WPT_BRIDGE_LOW;
               nxt_st.ping_on = 1'b0;
            end
         end
         WPT_IDCFG: begin
            if (i_rx.cfg) begin
               // profile follows receiver capability
               nxt_st.prof = i_rx.mag ? WPT_PROF_MAG :
                             i_rx.ext ? WPT_PROF_EXT :
                                        WPT_PROF_BASIC;
               nxt_st.contract = i_rx.max_pwr;
               nxt_st.cap      = i_rx.max_pwr;
               if (!i_rx.ext && !i_rx.mag) begin
                  nxt_st.phase = WPT_POWER;
                  nxt_st.cnt   = 32'h0000_0000;
               end
            end else if (st_ff.prof != WPT_PROF_BASIC && i_rx.nego_req) begin
               nxt_st.phase = WPT_NEGO;
            end
         end
         WPT_NEGO: begin
            if (i_q_own < i_q_min || i_q_own < i_q_rx) begin
               nxt_st.alarm   = 1'b1;
               nxt_st.phase   = WPT_SELECT;
               nxt_st.bridge  = `WPT_BRIDGE_LOW;
               nxt_st.ping_on = 1'b0;
            end else if (i_rx.nreq) begin
               // grant only what the contract can carry
               if (i_rx.nreq_pwr <= st_ff.contract) begin
                  nxt_st.grant = 1'b1;
                  nxt_st.cap   = i_rx.nreq_pwr;
               end else begin
                  nxt_st.deny = 1'b1;
               end
            end else if (i_rx.cal_req) begin
               nxt_st.ack   = 1'b1;
               nxt_st.phase = WPT_CALIB;
               nxt_st.cal_n = 2'h0;
            end
         end
         WPT_CALIB: begin
            if (i_rx.cal_pt) begin
               if (st_ff.cal_n == 2'h0) begin
                  nxt_st.loss0 = loss_now;
               end else begin
                  nxt_st.loss1 = loss_now;
                  nxt_st.phase = WPT_POWER;
                  nxt_st.cnt   = 32'h0000_0000;
               end
               nxt_st.cal_n = st_ff.cal_n + 2'h1;
            end
         end
         WPT_POWER: begin
            if (i_rx.auth_ok && st_ff.cal_n == 2'h2) begin
               nxt_st.authed = 1'b1;
            end
            if (i_rx.cep) begin
               nxt_st.cnt = 32'h0000_0000;
            end
            if (st_ff.cal_n == 2'h2 && loss_now > loss_ref) begin
               nxt_st.fo = 1'b1;
            end
            if (i_rx.ept || st_ff.fo ||
                (!i_rx.cep && st_ff.cnt >= CEP_CYC - 1)) begin
               nxt_st.phase   = WPT_SELECT;
               nxt_st.bridge  = `WPT_BRIDGE_LOW;
               nxt_st.ping_on = 1'b0;
               nxt_st.prof    = WPT_PROF_BASIC;
            end
         end
         default: begin
            nxt_st.phase = WPT_SELECT;
         end
      endcase
   end

   // ========================================================
   // state register; reset lands in selection at low bridge
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_ff <= '{phase: WPT_SELECT, prof: WPT_PROF_BASIC,
                    bridge: `WPT_BRIDGE_LOW, default: '0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // outputs come straight from state flops, except limit and power-on, registered here from nxt_st
   logic [15:0] lim_ff;
   logic        pwr_ff;
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         lim_ff <= 16'h0000;
         pwr_ff <= 1'b0;
      end else begin
         pwr_ff <= (nxt_st.phase == WPT_POWER);
         // extended receivers stay capped until authenticated
         if (nxt_st.phase != WPT_POWER) begin
            lim_ff <= 16'h0000;
         end else if (nxt_st.cal_n == 2'h2 && !nxt_st.authed) begin
            lim_ff <= (nxt_st.cap < `WPT_CAP_LOW_MW) ? nxt_st.cap
                                                      : `WPT_CAP_LOW_MW;
         end else begin
            lim_ff <= nxt_st.cap;
         end
      end
   end

   assign o_phase                       = st_ff.phase;
   assign o_profile                     = st_ff.prof;
   assign o_bridge_supply_voltage       = st_ff.bridge;
   assign o_ping_on                     = st_ff.ping_on;
   assign o_power_on                    = pwr_ff;
   assign o_pwr_limit                   = lim_ff;
   assign o_quality_factor_object_alarm = st_ff.alarm;
   assign o_cal_ack                     = st_ff.ack;
   assign o_grant                       = st_ff.grant;
   assign o_deny                        = st_ff.deny;
   assign o_fo_alarm                    = st_ff.fo;

   // ========================================================
   // checks; one clock domain, so clock and reset are given once
   default clocking cb_chk @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_arst_n);

   sequence s_ssp_in_ping;
      st_ff.phase == WPT_PING && i_rx.ssp;
   endsequence

   // own quality factor below floor or below what receiver reports
   sequence s_q_fail;
      st_ff.phase == WPT_NEGO && (i_q_own < i_q_min || i_q_own < i_q_rx);
   endsequence

   sequence s_back_to_select;
      st_ff.phase == WPT_SELECT && !o_ping_on;
   endsequence

   chk_ping_to_id: assert property (
      s_ssp_in_ping |=> st_ff.phase == WPT_IDCFG && st_ff.ping_on)
      else $error("ssp did not move to identification");
   chk_sel_bridge: assert property (
      st_ff.phase == WPT_SELECT && $past(st_ff.phase) == WPT_SELECT
      |-> o_bridge_supply_voltage == `WPT_BRIDGE_LOW && !o_ping_on)
      else $error("selection bridge not low");
   chk_ping_bound: assert property (
      st_ff.phase == WPT_PING |-> st_ff.cnt < PING_CYC)
      else $error("ping outlasted its length");
   chk_ping_level: assert property (
      st_ff.phase == WPT_PING
      |-> o_bridge_supply_voltage == `WPT_BRIDGE_PING && o_ping_on)
      else $error("ping power not at its fixed level");
   chk_sel_probe: assert property (
      st_ff.phase == WPT_SELECT && !i_obj_seen
      |=> st_ff.phase == WPT_SELECT)
      else $error("selection left without an object");
   chk_ept_stop: assert property (
      st_ff.phase == WPT_POWER && i_rx.ept
      |=> st_ff.phase == WPT_SELECT && !o_power_on)
      else $error("ept did not stop power");
   chk_qf_alarm: assert property (
      st_ff.phase == WPT_NEGO && i_q_own < i_q_min
      |=> o_quality_factor_object_alarm && st_ff.phase == WPT_SELECT)
      else $error("low quality factor not flagged");
   chk_q_reselect: assert property (
      s_q_fail |=> s_back_to_select)
      else $error("quality factor failure left ping on");
   chk_basic_skip: assert property (
      st_ff.prof == WPT_PROF_BASIC
      |-> st_ff.phase != WPT_NEGO && st_ff.phase != WPT_CALIB)
      else $error("basic profile in extended phase");
   chk_basic_power: assert property (
      st_ff.phase == WPT_IDCFG && i_rx.cfg && !i_rx.ext && !i_rx.mag
      |=> st_ff.phase == WPT_POWER && o_power_on)
      else $error("basic receiver not sent to power");
   chk_ext_class: assert property (
      st_ff.phase == WPT_IDCFG && i_rx.cfg && i_rx.ext && !i_rx.mag
      |=> st_ff.prof == WPT_PROF_EXT && st_ff.phase == WPT_IDCFG)
      else $error("extended receiver misclassified");
   chk_nego_entry: assert property (
      $changed(st_ff.phase) && st_ff.phase == WPT_NEGO
      |-> $past(st_ff.phase) == WPT_IDCFG)
      else $error("negotiation entered from wrong phase");
   chk_nego_answer: assert property (
      st_ff.phase == WPT_NEGO && i_rx.nreq && i_q_own >= i_q_min &&
      i_q_own >= i_q_rx
      |=> o_grant != o_deny)
      else $error("negotiation request unanswered");
   chk_grant_deny: assert property (
      !(o_grant && o_deny))
      else $error("grant and deny together");
   chk_cal_ack: assert property (
      $rose(st_ff.phase == WPT_CALIB) |-> o_cal_ack)
      else $error("calibration entered without ack");
   chk_cal_pair: assert property (
      st_ff.phase == WPT_CALIB && i_rx.cal_pt && st_ff.cal_n == 2'h1
      |=> st_ff.phase == WPT_POWER && o_power_on)
      else $error("second load point did not start power");
   chk_fo_exit: assert property (
      st_ff.phase == WPT_POWER && st_ff.fo |=> s_back_to_select)
      else $error("foreign object did not stop power");
   chk_cap_low: assert property (
      o_power_on && st_ff.cal_n == 2'h2 && !st_ff.authed
      |-> o_pwr_limit <= `WPT_CAP_LOW_MW)
      else $error("unauthenticated power above cap");
   chk_limit_idle: assert property (
      !o_power_on |-> o_pwr_limit == 16'h0000)
      else $error("power limit open outside transfer");
   chk_cep_timeout: assert property (
      st_ff.phase == WPT_POWER |-> st_ff.cnt < CEP_CYC)
      else $error("cep timeout missed");
   chk_cep_exit: assert property (
      st_ff.phase == WPT_POWER && !i_rx.cep && st_ff.cnt >= CEP_CYC - 1
      |=> s_back_to_select)
      else $error("power kept after cep timeout");
endmodule
`default_nettype wire

// ==== sim/wpt_rx_model.sv ====
// behavioural wireless power receiver that sends decoded packet events
`timescale 1ns/10ps
`default_nettype none

module wpt_rx_model import wpt_pkg::*; (
   input  wire logic    i_clk_sys, // system clock
   input  wire logic    i_ping_on, // transmitter ping power seen
   output var  wpt_rx_t o_rx       // decoded packet events
);
   initial o_rx = '0;

   // ====================================================================
   // packet sending
   // one event cycle, then data fields inverted so stale values never pass
   task automatic pulse(input wpt_rx_t ev);
      wpt_rx_t idle;
      idle          = '0;
      idle.max_pwr  = ~ev.max_pwr;
      idle.nreq_pwr = ~ev.nreq_pwr;
      @(posedge i_clk_sys);
      o_rx <= ev;
      @(posedge i_clk_sys);
      o_rx <= idle;
   endtask

   // answer the digital ping after dly cycles of powered ping
   task automatic answer_ping(input int dly);
      wpt_rx_t ev;
      ev     = '0;
      ev.ssp = 1'b1;
      repeat (dly) @(posedge i_clk_sys);
      if (i_ping_on === 1'b1) begin
         pulse(ev);
      end
   endtask

   // contract adjust request during negotiation
   task automatic request(input logic [15:0] pwr);
      wpt_rx_t ev;
      ev          = '0;
      ev.nreq     = 1'b1;
      ev.nreq_pwr = pwr;
      pulse(ev);
   endtask
endmodule
`default_nettype wire

// ==== sim/tb_wireless_power_tx_phase_control.sv ====
// self-checking bench of the transmitter phase sequencer
`timescale 1ns/10ps
`default_nettype none
`include "wpt_defines.svh"

module tb_wireless_power_tx_phase_control import wpt_pkg::*;;
   localparam int PING = 50;
   localparam int CEP  = 200;
   logic i_clk_sys, i_arst_n, i_obj_seen, ping_on, power_on, alarm;
   logic cal_ack, grant, deny, fo;
   logic [15:0] q_own, q_min, q_rx, tx_pwr, rx_pwr, limit;
   logic [3:0]  phase;
   logic [1:0]  profile;
   logic [7:0]  bridge;
   wpt_rx_t     rx;
   int          error_cnt, checks, cyc;

   wpt_phase_ctrl #(.PING_CYC(PING), .CEP_CYC(CEP)) i_dut (
      .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_obj_seen(i_obj_seen),
      .i_q_own(q_own), .i_q_min(q_min), .i_q_rx(q_rx), .i_tx_pwr(tx_pwr),
      .i_rx_pwr(rx_pwr), .i_rx(rx), .o_phase(phase), .o_profile(profile),
      .o_bridge_supply_voltage(bridge), .o_ping_on(ping_on),
      .o_power_on(power_on), .o_pwr_limit(limit),
      .o_quality_factor_object_alarm(alarm), .o_cal_ack(cal_ack),
      .o_grant(grant), .o_deny(deny), .o_fo_alarm(fo));
   wpt_rx_model i_rx_mdl (.i_clk_sys(i_clk_sys), .i_ping_on(ping_on),
      .o_rx(rx));

   // ====================================================================
   // clock, timeout ceiling well above the whole sequence
   initial begin
      i_clk_sys = 1'b0;
      forever #10 i_clk_sys = ~i_clk_sys;
   end
   always @(posedge i_clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         wrap_up();
      end
   end

   // ====================================================================
   // shared helpers
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask
   task automatic wait_ph(input logic [3:0] ph, input int lim);
      for (int i = 0; i < lim && phase !== ph; i++) step(1);
      chk(phase, ph);
   endtask
   // pulses seen over n cycles: cal_ack, grant, deny, fo
   task automatic watch(input logic [3:0] exp, input int n);
      logic [3:0] seen;
      seen = '0;
      // pulses stand from the edge the caller is on, so look first
      #1;
      repeat (n) begin
         seen |= {cal_ack, grant, deny, fo};
         step(1);
      end
      chk(seen, exp);
   endtask
   task automatic ev_send(input int kind, input logic [15:0] pwr);
      wpt_rx_t ev;
      ev = '0;
      case (kind)
         0: begin ev.cfg = 1'b1; ev.max_pwr = pwr; end
         1: begin ev.cfg = 1'b1; ev.ext = 1'b1; ev.max_pwr = pwr; end
         2: ev.nego_req = 1'b1;
         3: ev.cal_req = 1'b1;
         4: ev.cal_pt = 1'b1;
         5: ev.cep = 1'b1;
         7: ev.auth_ok = 1'b1;
         default: ev.ept = 1'b1;
      endcase
      i_rx_mdl.pulse(ev);
   endtask
   task automatic to_idcfg(input logic answer);
      @(posedge i_clk_sys);
      i_obj_seen <= 1'b1;
      @(posedge i_clk_sys);
      i_obj_seen <= 1'b0;
      wait_ph(WPT_PING, 4);
      chk(bridge, `WPT_BRIDGE_PING);
      chk(ping_on, 1'b1);
      if (answer) begin
         i_rx_mdl.answer_ping(3);
         wait_ph(WPT_IDCFG, 4);
         chk(ping_on, 1'b1);
      end
   endtask

   // ====================================================================
   // scenarios
   task automatic t_basic();
      to_idcfg(1'b1);
      ev_send(0, 16'h0BB8);
      wait_ph(WPT_POWER, 4);
      chk(profile, WPT_PROF_BASIC);
      chk(limit, 16'h0BB8);
      ev_send(2, 16'h0000);
      step(3);
      chk(phase, WPT_POWER);
      ev_send(6, 16'h0000);
      wait_ph(WPT_SELECT, 3);
      chk({power_on, bridge}, {1'b0, `WPT_BRIDGE_LOW});
   endtask
   task automatic t_ping_silent();
      to_idcfg(1'b0);
      step(PING - 6);
      chk(phase, WPT_PING);
      wait_ph(WPT_SELECT, 12);
      chk(bridge, `WPT_BRIDGE_LOW);
   endtask
   task automatic t_cep_timeout();
      to_idcfg(1'b1);
      ev_send(0, 16'h0BB8);
      wait_ph(WPT_POWER, 4);
      ev_send(5, 16'h0000);
      step(CEP - 10);
      chk(phase, WPT_POWER);
      wait_ph(WPT_SELECT, 20);
   endtask
   task automatic t_extended();
      to_idcfg(1'b1);
      ev_send(1, 16'h2EE0);
      step(5);
      chk({phase, 2'b00, profile}, {WPT_IDCFG, 2'b00, WPT_PROF_EXT});
      ev_send(2, 16'h0000);
      wait_ph(WPT_NEGO, 3);
      i_rx_mdl.request(16'h2000);
      watch(4'b0100, 3);
      i_rx_mdl.request(16'h3000);
      watch(4'b0010, 3);
      ev_send(3, 16'h0000);
      watch(4'b1000, 2);
      chk(phase, WPT_CALIB);
      @(posedge i_clk_sys);
      tx_pwr <= 16'h03E8;
      rx_pwr <= 16'h0384;
      ev_send(4, 16'h0000);
      step(2);
      chk(phase, WPT_CALIB);
      ev_send(4, 16'h0000);
      wait_ph(WPT_POWER, 3);
      ev_send(5, 16'h0000);
      chk(limit, `WPT_CAP_LOW_MW);
      ev_send(7, 16'h0000);
      step(1);
      chk(limit, 16'h2000);
      @(posedge i_clk_sys);
      tx_pwr <= 16'h07D0;
      watch(4'b0001, 4);
      wait_ph(WPT_SELECT, 4);
      tx_pwr <= 16'h03E8;
   endtask
   task automatic t_q_fail();
      to_idcfg(1'b1);
      ev_send(1, 16'h2EE0);
      @(posedge i_clk_sys);
      q_own <= 16'h0028;
      ev_send(2, 16'h0000);
      wait_ph(WPT_SELECT, 5);
      chk(alarm, 1'b1);
      chk(ping_on, 1'b0);
      q_own <= 16'h0064;
   endtask

   // ====================================================================
   // reset and main sequence
   initial begin
      {error_cnt, checks, cyc} = '0;
      {i_arst_n, i_obj_seen, tx_pwr, rx_pwr} = '0;
      {q_own, q_min, q_rx} = {16'h0064, 16'h0032, 16'h0050};
      repeat (16) @(posedge i_clk_sys);
      i_arst_n <= 1'b1;
      step(2);
      chk({phase, bridge}, {WPT_SELECT, `WPT_BRIDGE_LOW});
      t_basic();
      t_ping_silent();
      t_cep_timeout();
      t_extended();
      t_q_fail();
      wrap_up();
   end

   task automatic wrap_up();
      $display("checks=%0d error_cnt=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
endmodule
`default_nettype wire
